//--- logic/vfcfg_pkg.sv
`default_nettype none
package vfcfg_pkg;
  // ==========================================================
  // Bus and field widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SET_W = 16;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_PATTERN = 8'h00;
  localparam logic [7:0] OFS_M1_BASE = 8'h04;
  localparam logic [7:0] OFS_BASE_VOLT = 8'h20;
  localparam logic [7:0] OFS_M2_BASE = 8'h24;
  localparam logic [7:0] OFS_CTRL_METHOD = 8'h40;
  localparam logic [7:0] OFS_MOTOR_SEL = 8'h44;
  localparam logic [7:0] OFS_PULSES_REV = 8'h48;
  localparam logic [7:0] OFS_DIR_SEL = 8'h4c;
  localparam logic [7:0] OFS_MON_DIV = 8'h50;
  localparam logic [7:0] OFS_VOLT_OUT = 8'h54;
  localparam logic [7:0] OFS_POSITION = 8'h58;
  localparam logic [7:0] OFS_REVS = 8'h5c;
  localparam logic [7:0] OFS_STATUS = 8'h60;

  // ==========================================================
  // Curve points, units of 0.1 Hz and 0.1 V
  localparam int NUM_PTS = 7;
  typedef enum logic [2:0] {
    PT_FREQ_TOP = 3'b000,
    PT_VOLT_TOP = 3'b001,
    PT_FREQ_BASE = 3'b010,
    PT_FREQ_MID = 3'b011,
    PT_VOLT_MID = 3'b100,
    PT_FREQ_BOT = 3'b101,
    PT_VOLT_BOT = 3'b110
  } vfcfg_point_t;
  localparam logic [6:0] PT_IS_VOLT = 7'h52;
  localparam logic [15:0] PT_RESET [NUM_PTS] = '{16'h0258, 16'h07d0,
    16'h0258, 16'h001e, 16'h0096, 16'h000f, 16'h005a};
  localparam logic [15:0] PT_LO [NUM_PTS] = '{16'h0190, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] PT_HI [NUM_PTS] = '{16'h0fa0, 16'h09f6,
    16'h0fa0, 16'h0fa0, 16'h09f6, 16'h0fa0, 16'h09f6};
  localparam logic [15:0] BASE_VOLT_RESET = 16'h0000;
  // Middle and bottom point defaults per control method
  localparam logic [15:0] METHOD_DEFAULT [4][4] = '{
    '{16'h001e, 16'h0096, 16'h000f, 16'h005a},
    '{16'h001e, 16'h0096, 16'h000f, 16'h005a},
    '{16'h001e, 16'h006e, 16'h0005, 16'h0014},
    '{16'h001e, 16'h0000, 16'h0000, 16'h0000}};
  localparam logic [3:0] PATTERN_CUSTOM = 4'hf;
  localparam logic [1:0] METHOD_RESET = 2'h0;

  // ==========================================================
  // Encoder and pulse monitor
  localparam logic [15:0] PPR_RESET = 16'h0258;
  localparam logic [15:0] PPR_MAX = 16'hea60;
  localparam logic [7:0] MON_DIV_RESET = 8'h01;
  localparam logic [7:0] MON_DIV_N_STEP = 8'h64;
  localparam logic [7:0] MON_DIV_M_MAX = 8'h20;
  localparam int DIV_STEPS = 32;
endpackage
`default_nettype wire

//--- logic/vfcfg_curve_if.sv
`timescale 1ns/100ps
`default_nettype none
interface vfcfg_curve_if;
  logic start;
  logic [15:0] xOff;
  logic [15:0] span;
  logic [15:0] vStart;
  logic [15:0] vEnd;
  logic busy;
  logic done;
  logic [15:0] volt;
  modport requester (output start, xOff, span, vStart, vEnd,
    input busy, done, volt);
  modport solver (input start, xOff, span, vStart, vEnd,
    output busy, done, volt);
endinterface
`default_nettype wire

//--- logic/vfcfg_interp.sv
`timescale 1ns/100ps
`default_nettype none
module vfcfg_interp
  import vfcfg_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  vfcfg_curve_if.solver curve
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } vfcfg_istate_t;

  vfcfg_istate_t state;
  logic [31:0] dvd;
  logic [16:0] rem;
  logic [5:0] steps;
  logic [15:0] span;
  logic [15:0] vStart;
  logic neg;

  // ==========================================================
  // Signed slope split into magnitude and sign
  wire startNeg = curve.vEnd < curve.vStart;
  wire [15:0] dMag = startNeg ? curve.vStart - curve.vEnd
                              : curve.vEnd - curve.vStart;
  wire [31:0] product = dMag * curve.xOff;
  wire [16:0] trial = {rem[15:0], dvd[31]};
  wire fits = trial >= {1'b0, span};
  wire [16:0] nextRem = fits ? trial - {1'b0, span} : trial;
  wire [15:0] quo = dvd[15:0];
  wire [15:0] nextVolt = span == 16'h0000 ? vStart
                       : neg ? vStart - quo : vStart + quo;

  assign curve.busy = state != ST_IDLE;
  assign curve.done = state == ST_DONE;
  // Valid while done is high, quotient is final then
  assign curve.volt = nextVolt;

  // ==========================================================
  // Restoring divider, one quotient bit per clock
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      dvd <= 32'h0000_0000;
      rem <= 17'h00000;
      steps <= 6'h00;
      span <= 16'h0000;
      vStart <= 16'h0000;
      neg <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: if (curve.start) begin
          dvd <= product;
          rem <= 17'h00000;
          steps <= 6'h00;
          span <= curve.span;
          vStart <= curve.vStart;
          neg <= startNeg;
          state <= ST_RUN;
        end
        ST_RUN: begin
          dvd <= {dvd[30:0], fits};
          rem <= nextRem;
          steps <= steps + 6'h01;
          if (steps == 6'(DIV_STEPS - 1)) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- logic/vfcfg_core.sv
// Overview of operation
// - Pattern code 0 to E picks a preset curve, F the custom curve; no presets here, voltOut always uses the stored breakpoints.
// - Seven breakpoint settings take writes only while the pattern is F.
// - Equal middle and minimum frequency: middle voltage is ignored.
// - Voltages span 0 to 255.0 V, doubled with defaults for 400 V class.
// - Zero base voltage takes max voltage when auto-tuning completes.
// - Control method change reloads middle and minimum points per method.
// - Motor-2 breakpoint set behaves like motor-1 set.
// - Encoder pulses per revolution 0 to 60000, default 600.
// - Direction 0: A leading is forward; 1: B leading is forward.
// - Monitor divider only acts when the complementary card is fitted.
// - Divider code n,m gives output to input pulse ratio (1+n)/m.
// - Ratio stays between 1/32 and 1, default setting 1.
`timescale 1ns/100ps
`default_nettype none
module vfcfg_core
  import vfcfg_pkg::*;
#(
  parameter bit HIGH_VOLT_CLASS = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  input wire logic [SET_W-1:0] freqRef,
  input wire logic autoTuneDone,
  input wire logic encCardFitted,
  input wire logic phaseA,
  input wire logic phaseB,
  output logic [SET_W-1:0] voltOut,
  output logic pulseMonitorOut,
  output logic rotForward
);
  // ==========================================================
  // Voltage scaling for the 400 V class
  function automatic logic [15:0] scaleV(input logic [15:0] v,
                                         input logic isVolt);
    scaleV = (isVolt && HIGH_VOLT_CLASS) ? {v[14:0], 1'b0} : v;
  endfunction

  localparam logic [15:0] VOLT_HI = scaleV(PT_HI[PT_VOLT_TOP], 1'b1);

  logic [3:0] pattern;
  logic [1:0] ctrlMethod;
  logic motorSel;
  logic [15:0] pt [2*NUM_PTS];
  logic [15:0] baseVolt;
  logic [15:0] pulsesRev;
  logic dirSel;
  logic [7:0] monDiv;
  logic prevA;
  logic prevB;
  logic [31:0] position;
  logic [17:0] edgeInRev;
  logic [15:0] revs;
  logic [7:0] monAcc;
  logic [DATA_W-1:0] rdHold;

  // ==========================================================
  // Shared write decode
  wire [15:0] wrVal = regWrData[15:0];
  wire upperZero = regWrData[31:16] == 16'h0000;
  wire customCurve = pattern == PATTERN_CUSTOM;
  wire [1:0] newMethod = regWrData[1:0];
  wire methodChange = regWrite && regAddr == OFS_CTRL_METHOD
                      && newMethod != ctrlMethod;
  wire baseVoltWr = regWrite && regAddr == OFS_BASE_VOLT
                    && upperZero && wrVal <= VOLT_HI;
  wire pprWr = regWrite && regAddr == OFS_PULSES_REV
               && upperZero && wrVal <= PPR_MAX;
  wire [7:0] divVal = regWrData[7:0];
  wire divHighN = divVal > MON_DIV_N_STEP;
  wire [7:0] divValM = divHighN ? divVal - MON_DIV_N_STEP : divVal;
  wire divValid = regWrData[31:8] == 24'h000000
                  && divVal <= MON_DIV_N_STEP + MON_DIV_M_MAX
                  && divValM <= MON_DIV_M_MAX
                  && divValM >= (divHighN ? 8'h02 : 8'h01);
  wire divWr = regWrite && regAddr == OFS_MON_DIV && divValid;

  // ==========================================================
  // Breakpoint settings for both motors
  logic [15:0] rdChain [2*NUM_PTS+1];
  assign rdChain[0] = 16'h0000;

  for (genvar k = 0; k < 2 * NUM_PTS; k++) begin : g_pt
    localparam int PT = k % NUM_PTS;
    localparam int J = PT >= 3 ? PT - 3 : 0;
    localparam logic [7:0] ADDR =
      (k < NUM_PTS ? OFS_M1_BASE : OFS_M2_BASE) + 8'(4 * PT);
    localparam logic ISV = PT_IS_VOLT[PT];
    localparam logic [15:0] LO = scaleV(PT_LO[PT], ISV);
    localparam logic [15:0] HI = scaleV(PT_HI[PT], ISV);
    localparam logic [15:0] RST = scaleV(PT_RESET[PT], ISV);
    wire hit = regAddr == ADDR;
    wire inRange = upperZero && wrVal >= LO && wrVal <= HI;
    wire wrEn = regWrite && hit && customCurve && inRange;
    wire reload = methodChange && PT >= 3;
    wire [15:0] reloadVal = scaleV(METHOD_DEFAULT[newMethod][J], ISV);
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        pt[k] <= RST;
      end else if (reload) begin
        pt[k] <= reloadVal;
      end else if (wrEn) begin
        pt[k] <= wrVal;
      end
    end
    assign rdChain[k+1] = rdChain[k] | (hit ? pt[k] : 16'h0000);
  end

  // ==========================================================
  // Plain configuration registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pattern <= PATTERN_CUSTOM;
      ctrlMethod <= METHOD_RESET;
      motorSel <= 1'b0;
      dirSel <= 1'b0;
    end else if (regWrite) begin
      if (regAddr == OFS_PATTERN) begin
        pattern <= regWrData[3:0];
      end
      if (methodChange) begin
        ctrlMethod <= newMethod;
      end
      if (regAddr == OFS_MOTOR_SEL) begin
        motorSel <= regWrData[0];
      end
      if (regAddr == OFS_DIR_SEL) begin
        dirSel <= regWrData[0];
      end
    end
  end

  // Auto-tune overwrite beats a software write in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      baseVolt <= BASE_VOLT_RESET;
    end else if (autoTuneDone && baseVolt == 16'h0000) begin
      baseVolt <= pt[PT_VOLT_TOP];
    end else if (baseVoltWr) begin
      baseVolt <= wrVal;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pulsesRev <= PPR_RESET;
      monDiv <= MON_DIV_RESET;
    end else begin
      if (pprWr) begin
        pulsesRev <= wrVal;
      end
      if (divWr) begin
        monDiv <= divVal;
      end
    end
  end

  // ==========================================================
  // Curve segment selection for the active motor
  wire [3:0] mBase = motorSel ? 4'h7 : 4'h0;
  wire [15:0] vTop = pt[mBase + 4'(PT_VOLT_TOP)];
  wire [15:0] fBase = pt[mBase + 4'(PT_FREQ_BASE)];
  wire [15:0] fMid = pt[mBase + 4'(PT_FREQ_MID)];
  wire [15:0] vMid = pt[mBase + 4'(PT_VOLT_MID)];
  wire [15:0] fBot = pt[mBase + 4'(PT_FREQ_BOT)];
  wire [15:0] vBot = pt[mBase + 4'(PT_VOLT_BOT)];
  wire straight = fMid == fBot;
  wire [15:0] lowV = straight ? vBot : vMid;
  wire aboveBase = freqRef >= fBase;
  wire upperSeg = !aboveBase && freqRef >= fMid;
  wire lowerSeg = !aboveBase && !upperSeg && freqRef > fBot;
  wire flat = !upperSeg && !lowerSeg;
  wire [15:0] flatV = aboveBase ? vTop : vBot;

  vfcfg_curve_if curve ();

  assign curve.start = !curve.busy;
  assign curve.xOff = upperSeg ? freqRef - fMid
                    : lowerSeg ? freqRef - fBot : 16'h0000;
  assign curve.span = upperSeg ? fBase - fMid
                    : lowerSeg ? fMid - fBot : 16'h0001;
  assign curve.vStart = flat ? flatV : upperSeg ? lowV : vBot;
  assign curve.vEnd = flat ? flatV : upperSeg ? vTop : vMid;

  vfcfg_interp u_interp (
    .clock(clock),
    .reset_n(reset_n),
    .curve(curve)
  );

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      voltOut <= 16'h0000;
    end else if (curve.done) begin
      voltOut <= curve.volt;
    end
  end

  // ==========================================================
  // Quadrature decode
  wire changeA = phaseA ^ prevA;
  wire changeB = phaseB ^ prevB;
  wire step = changeA ^ changeB;
  wire aLeads = !(prevA ^ phaseB);
  wire stepFwd = aLeads ^ dirSel;
  wire [17:0] edgesRev = {pulsesRev, 2'b00};
  wire revCount = pulsesRev != 16'h0000;
  wire revWrapUp = edgeInRev >= edgesRev - 18'h00001;
  wire revWrapDown = edgeInRev == 18'h00000;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prevA <= 1'b0;
      prevB <= 1'b0;
      position <= 32'h0000_0000;
      rotForward <= 1'b1;
    end else begin
      prevA <= phaseA;
      prevB <= phaseB;
      if (step) begin
        position <= stepFwd ? position + 32'h1
                            : position - 32'h1;
        rotForward <= stepFwd;
      end
    end
  end

  // Revolution tally from edges, four per pulse period
  always_ff @(posedge clock) begin
    if (!reset_n || !revCount) begin
      edgeInRev <= 18'h00000;
      revs <= 16'h0000;
    end else if (step && stepFwd) begin
      edgeInRev <= revWrapUp ? 18'h00000 : edgeInRev + 18'h00001;
      if (revWrapUp) begin
        revs <= revs + 16'h0001;
      end
    end else if (step) begin
      edgeInRev <= revWrapDown ? edgesRev - 18'h00001
                               : edgeInRev - 18'h00001;
      if (revWrapDown) begin
        revs <= revs - 16'h0001;
      end
    end
  end

  // ==========================================================
  // Pulse monitor: each phase A edge adds 1+n, toggle on reaching m
  wire divN = monDiv > MON_DIV_N_STEP;
  wire [7:0] divM = divN ? monDiv - MON_DIV_N_STEP : monDiv;
  wire [7:0] monAdd = divN ? 8'h02 : 8'h01;
  wire [7:0] monSum = monAcc + monAdd;
  wire monFire = monSum >= divM;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      monAcc <= 8'h00;
      pulseMonitorOut <= 1'b0;
    end else if (!encCardFitted) begin
      monAcc <= 8'h00;
      pulseMonitorOut <= phaseA;
    end else if (changeA) begin
      monAcc <= monFire ? monSum - divM : monSum;
      if (monFire) begin
        pulseMonitorOut <= !pulseMonitorOut;
      end
    end
  end

  // ==========================================================
  // Read path: data in the cycle after the strobe only
  wire [31:0] rdMux =
      regAddr == OFS_PATTERN ? {28'h0, pattern}
    : regAddr == OFS_BASE_VOLT ? {16'h0, baseVolt}
    : regAddr == OFS_CTRL_METHOD ? {30'h0, ctrlMethod}
    : regAddr == OFS_MOTOR_SEL ? {31'h0, motorSel}
    : regAddr == OFS_PULSES_REV ? {16'h0, pulsesRev}
    : regAddr == OFS_DIR_SEL ? {31'h0, dirSel}
    : regAddr == OFS_MON_DIV ? {24'h0, monDiv}
    : regAddr == OFS_VOLT_OUT ? {16'h0, voltOut}
    : regAddr == OFS_POSITION ? position
    : regAddr == OFS_REVS ? {16'h0, revs}
    : regAddr == OFS_STATUS ? {29'h0, customCurve, encCardFitted,
                               rotForward}
    : {16'h0, rdChain[2*NUM_PTS]};

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdHold <= 32'h0000_0000;
    end else begin
      rdHold <= regRead ? rdMux : 32'h0000_0000;
    end
  end

  assign regRdData = rdHold;
endmodule
`default_nettype wire

//--- sim/vfcfg_enc_model.sv
`timescale 1ns/100ps
`default_nettype none
module vfcfg_enc_model (
  input wire logic clock,
  input wire logic stepReq,
  input wire logic stepFwd,
  input wire logic glitch,
  output logic phaseA,
  output logic phaseB
);
  // ==========================================================
  // Two-phase shaft pulse source
  logic [1:0] idx = 2'h0;

  // Gray order; forward lets phase A lead, glitch flips both at once
  always_ff @(posedge clock) begin
    if (glitch) begin
      idx <= idx + 2'h2;
    end else if (stepReq) begin
      idx <= stepFwd ? idx + 2'h1 : idx - 2'h1;
    end
  end

  assign phaseA = idx[0] ^ idx[1];
  assign phaseB = idx[1];
endmodule
`default_nettype wire

//--- sim/vfcfg_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module vfcfg_core_asserts
  import vfcfg_pkg::*;
#(
  parameter bit HIGH_VOLT_CLASS = 1'b0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic [SET_W-1:0] freqRef,
  input wire logic autoTuneDone,
  input wire logic encCardFitted,
  input wire logic phaseA,
  input wire logic phaseB,
  input wire logic [SET_W-1:0] voltOut,
  input wire logic pulseMonitorOut,
  input wire logic rotForward
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // Register bus
  property p_rd_idle;
    !regRead |=> regRdData == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data seen without a read");
  property p_unmapped;
    regRead && regAddr > OFS_STATUS |=> regRdData == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");
  property p_pat_echo;
    regWrite && regAddr == OFS_PATTERN && regWrData[31:4] == '0 ##2
      regRead && regAddr == OFS_PATTERN
      |=> regRdData[3:0] == $past(regWrData[3:0], 3);
  endproperty
  a_pat_echo: assert property (p_pat_echo)
    else $error("pattern code not read back");
  property p_dir_upper;
    regRead && regAddr == OFS_DIR_SEL |=> regRdData[31:1] == '0;
  endproperty
  a_dir_upper: assert property (p_dir_upper)
    else $error("direction register has upper bits");
  property p_stat_rot;
    regRead && regAddr == OFS_STATUS |=> regRdData[0] == $past(rotForward);
  endproperty
  a_stat_rot: assert property (p_stat_rot)
    else $error("status sense bit differs from sense output");

  // ==========================================================
  // Encoder decode and pulse monitor
  property p_rot_hold;
    $changed(phaseA) == $changed(phaseB) |=> $stable(rotForward);
  endproperty
  a_rot_hold: assert property (p_rot_hold)
    else $error("sense changed without a single phase step");
  property p_mon_copy;
    !encCardFitted |=> pulseMonitorOut == $past(phaseA);
  endproperty
  a_mon_copy: assert property (p_mon_copy)
    else $error("monitor not a copy of phase A without card");
  property p_mon_hold;
    encCardFitted && $stable(phaseA) |=> $stable(pulseMonitorOut);
  endproperty
  a_mon_hold: assert property (p_mon_hold)
    else $error("monitor moved without a phase A edge");

  c_mon_div: cover property (encCardFitted && $changed(pulseMonitorOut));
  c_status: cover property (regRead && regAddr == OFS_STATUS);
  c_sense: cover property ($changed(rotForward));
endmodule

bind vfcfg_core vfcfg_core_asserts #(
  .HIGH_VOLT_CLASS(HIGH_VOLT_CLASS)
) chk_u (
  .clock(clock),
  .reset_n(reset_n),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWrite(regWrite),
  .regRead(regRead),
  .regRdData(regRdData),
  .freqRef(freqRef),
  .autoTuneDone(autoTuneDone),
  .encCardFitted(encCardFitted),
  .phaseA(phaseA),
  .phaseB(phaseB),
  .voltOut(voltOut),
  .pulseMonitorOut(pulseMonitorOut),
  .rotForward(rotForward)
);
`default_nettype wire

//--- sim/vf_pattern_and_encoder_config_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module vf_pattern_and_encoder_config_tb_top
  import vfcfg_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic [SET_W-1:0] freqRef = '0;
  logic [SET_W-1:0] voltOut;
  logic autoTuneDone = 1'b0;
  logic encCardFitted = 1'b0;
  logic stepReq = 1'b0, stepFwd = 1'b0, glitch = 1'b0, monPrev = 1'b0;
  logic phaseA, phaseB, pulseMonitorOut, rotForward;
  int errors = 0;
  int checks = 0;
  int togs = 0;

  always #2 clock = ~clock;

  vfcfg_core dut_u (.clock(clock), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .freqRef(freqRef), .autoTuneDone(autoTuneDone),
    .encCardFitted(encCardFitted), .phaseA(phaseA), .phaseB(phaseB),
    .voltOut(voltOut), .pulseMonitorOut(pulseMonitorOut),
    .rotForward(rotForward));
  vfcfg_enc_model enc_u (.clock(clock), .stepReq(stepReq),
    .stepFwd(stepFwd), .glitch(glitch), .phaseA(phaseA), .phaseB(phaseB));

  // ==========================================================
  // Bus, encoder and curve helpers
  always @(posedge clock) begin
    monPrev <= pulseMonitorOut;
    if (pulseMonitorOut !== monPrev) begin
      togs <= togs + 1;
    end
  end
  task automatic conclude;
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    `CHK($sformatf("reg %h", a), e, regRdData)
  endtask
  task automatic pulse(input bit tune);
    @(posedge clock);
    if (tune) begin
      autoTuneDone <= 1'b1;
    end else begin
      glitch <= 1'b1;
    end
    @(posedge clock);
    autoTuneDone <= 1'b0;
    glitch <= 1'b0;
  endtask
  task automatic step(input logic fwd, input int n);
    @(posedge clock);
    stepFwd <= fwd;
    stepReq <= 1'b1;
    repeat (n) @(posedge clock);
    stepReq <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
  endtask
  task automatic vchk(input logic [15:0] f, input logic [15:0] e);
    int k;
    @(posedge clock);
    freqRef <= f;
    #1;
    for (k = 0; k < 200 && voltOut !== e; k++) begin
      @(posedge clock);
      #1;
    end
    `CHK("voltOut", e, voltOut)
  endtask
  task automatic mon(input logic fit, input logic [31:0] dv, input int e);
    int t0;
    @(posedge clock);
    encCardFitted <= fit;
    wr(OFS_MON_DIV, dv);
    repeat (4) @(posedge clock);
    t0 = togs;
    step(1'b1, 16);
    `CHK("monitor toggles", e, togs - t0)
  endtask

  initial begin
    #200000;
    errors++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    int i, m;
    logic [15:0] dflt [7];
    logic [15:0] meth [2][5];
    dflt = '{16'd600, 16'd2000, 16'd600, 16'd30, 16'd150, 16'd15, 16'd90};
    meth = '{'{16'd2, 16'd30, 16'd110, 16'd5, 16'd20},
      '{16'd0, 16'd30, 16'd150, 16'd15, 16'd90}};
    repeat (5) @(posedge clock);
    #1;
    `CHK("voltOut", 16'h0000, voltOut)
    `CHK("monitor", 1'b0, pulseMonitorOut)
    `CHK("rotForward", 1'b1, rotForward)
    `CHK("regRdData", 32'h0, regRdData)
    @(posedge clock);
    reset_n <= 1'b1;
    rd(OFS_PATTERN, 32'hf);
    for (i = 0; i < 7; i++) begin
      rd(OFS_M1_BASE + 8'(4 * i), {16'h0, dflt[i]});
      rd(OFS_M2_BASE + 8'(4 * i), {16'h0, dflt[i]});
    end
    rd(OFS_BASE_VOLT, 32'h0);
    rd(OFS_PULSES_REV, 32'd600);
    rd(OFS_DIR_SEL, 32'h0);
    rd(OFS_MON_DIV, 32'h1);
    rd(8'h64, 32'h0);
    // Range limits
    wr(OFS_M1_BASE, 32'd399);
    rd(OFS_M1_BASE, 32'd600);
    wr(OFS_M1_BASE, 32'd4000);
    wr(OFS_M1_BASE, 32'd4001);
    rd(OFS_M1_BASE, 32'd4000);
    wr(OFS_M1_BASE + 8'h04, 32'd2551);
    rd(OFS_M1_BASE + 8'h04, 32'd2000);
    wr(OFS_M1_BASE + 8'h04, 32'd2550);
    rd(OFS_M1_BASE + 8'h04, 32'd2550);
    wr(OFS_PULSES_REV, 32'd60001);
    rd(OFS_PULSES_REV, 32'd600);
    wr(OFS_PULSES_REV, 32'd60000);
    rd(OFS_PULSES_REV, 32'd60000);
    // Every pattern code, breakpoint lock
    for (i = 0; i < 16; i++) begin
      wr(OFS_PATTERN, 32'(i));
      rd(OFS_PATTERN, 32'(i));
      wr(OFS_M1_BASE + 8'h18, 32'd100 + 32'(i));
      rd(OFS_M1_BASE + 8'h18, (i == 15) ? 32'd115 : 32'd90);
    end
    pulse(1'b1);
    rd(OFS_BASE_VOLT, 32'd2550);
    wr(OFS_BASE_VOLT, 32'd1000);
    pulse(1'b1);
    rd(OFS_BASE_VOLT, 32'd1000);
    // Control method reload, both motors
    wr(OFS_M1_BASE + 8'h10, 32'd500);
    for (m = 0; m < 2; m++) begin
      wr(OFS_CTRL_METHOD, 32'(meth[m][0]));
      for (i = 0; i < 4; i++) begin
        rd(OFS_M1_BASE + 8'(12 + 4 * i), 32'(meth[m][i + 1]));
        rd(OFS_M2_BASE + 8'(12 + 4 * i), 32'(meth[m][i + 1]));
      end
    end
    // Curve points
    vchk(16'd0, 16'd90);
    vchk(16'd1000, 16'd2550);
    vchk(16'd30, 16'd150);
    vchk(16'd315, 16'd1350);
    wr(OFS_M1_BASE + 8'h10, 32'd1000);
    wr(OFS_M1_BASE + 8'h14, 32'd30);
    vchk(16'd315, 16'd1320);
    wr(OFS_MOTOR_SEL, 32'h1);
    vchk(16'd315, 16'd1075);
    // Encoder sense and position
    step(1'b1, 8);
    `CHK("rotForward", 1'b1, rotForward)
    rd(OFS_POSITION, 32'd8);
    step(1'b0, 3);
    `CHK("rotForward", 1'b0, rotForward)
    pulse(1'b0);
    rd(OFS_POSITION, 32'd5);
    rd(OFS_STATUS, 32'h4);
    wr(OFS_DIR_SEL, 32'h1);
    rd(OFS_DIR_SEL, 32'h1);
    step(1'b0, 2);
    `CHK("rotForward", 1'b1, rotForward)
    step(1'b1, 1);
    `CHK("rotForward", 1'b0, rotForward)
    rd(OFS_POSITION, 32'd6);
    // Four edges per revolution with one pulse per turn
    wr(OFS_PULSES_REV, 32'd0);
    wr(OFS_PULSES_REV, 32'd1);
    step(1'b0, 9);
    rd(OFS_REVS, 32'd2);
    // Pulse monitor divider
    mon(1'b1, 32'd1, 8);
    mon(1'b1, 32'd2, 4);
    mon(1'b1, 32'd116, 1);
    wr(OFS_MON_DIV, 32'd101);
    wr(OFS_MON_DIV, 32'd33);
    rd(OFS_MON_DIV, 32'd116);
    mon(1'b0, 32'd2, 8);
    conclude();
  end
endmodule
`default_nettype wire
